// >>> sltx_top.sv
/*
 * transport layer: frames samples, builds alignment, scrambles, test output.
 * assumes an octet-wide 8b/10b encoder downstream and an AXI4-Lite master.
 */
`include "sltx_map.svh"

// Notes on behaviour
// [RULE1] one lane at twenty times the sample rate.
// [RULE2] fixed frame: two octets, one sample.
// [RULE3] converter, resolution and control fields fixed.
// [RULE4] octets per frame two, sent as one.
// [RULE5] frames per multiframe 9 to 32, sent minus one.
// [RULE6] lanes sent as zero; lane id zero.
// [RULE7] resolution and sample bits sixteen, sent fifteen.
// [RULE8] samples per frame one, sent zero.
// [RULE9] converters one, field one.
// [RULE10] unused configuration fields sent zero.
// [RULE11] scrambling field mirrors the register bit.
// [RULE12] offset fields reduced by one.
// [RULE13] standard scrambler, off after reset, on by write.
// [RULE14] descrambler may lock early during alignment.
// [RULE15] alignment octets never scrambled.
// [RULE16] selector: D21.5, K28.5, endless alignment, ramp.
// [RULE17] D21.5 gives alternating line bits.
// [RULE18] transport, RPAT and JSPAT patterns not offered.
// [RULE19] ramp after alignment steps over both octets.
// [RULE20] checksum 34 plus encoded K plus scrambling, mod 256.
// [RULE21] alignment: four multiframes from boundary after sync release.
// [RULE22] sync low under four frames ignored.
module sltx_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // sample input, one 16-bit sample per frame
    input  wire logic [15:0] sample_data,
    // link sync request from receiver, asynchronous
    input  wire logic        link_sync_request_n,
    // octet stream to the 8b/10b encoder
    output logic [7:0]       lane_octet,
    output logic             lane_is_ctrl,
    output logic             lane_frame_start,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);

    // registers
    logic                    scr_en;
    sltx_pkg::sltx_pat_t     tpat;
    logic [5:0]              k_frames;
    logic [15:0]             ramp_step;

    // bus handshake state
    logic                    aw_held;
    logic                    w_held;
    logic [7:0]              aw_addr;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;

    // link state
    sltx_pkg::sltx_state_t   state;
    logic                    sync_meta;
    logic                    sync_s;
    logic [2:0]              sync_low_cnt;
    logic                    sync_req;
    logic                    octet_sel;
    logic [5:0]              frame_cnt;
    logic [1:0]              mf_cnt;
    logic [14:0]             lfsr;
    logic [15:0]             ramp_val;
    logic [15:0]             held_sample;

    // configuration octets, encoded [RULE12]
    wire  [4:0]  k_enc    = 5'(k_frames - 6'h01);                  // [RULE5]
    wire  [7:0]  fchk     = 8'(`SLTX_FCHK_BASE + {3'h0, k_enc} + {7'h00, scr_en}); // [RULE20]
    wire  [7:0]  cfg_oct [0:13];
    assign cfg_oct[0]  = 8'h00;                                     // device id, [RULE10]
    assign cfg_oct[1]  = 8'h00;                                     // adjcnt, bank [RULE10]
    assign cfg_oct[2]  = 8'h00;                                     // adjdir, phadj, lid [RULE6]
    assign cfg_oct[3]  = {scr_en, 2'h0, `SLTX_ENC_L};               // [RULE11] [RULE6]
    assign cfg_oct[4]  = `SLTX_ENC_F;                               // [RULE4] [RULE2]
    assign cfg_oct[5]  = {3'h0, k_enc};                             // [RULE5]
    assign cfg_oct[6]  = `SLTX_ENC_M;                               // [RULE9] [RULE3]
    assign cfg_oct[7]  = {3'h0, `SLTX_ENC_N};                       // cs zero [RULE7] [RULE10]
    assign cfg_oct[8]  = {`SLTX_SUBCLASS, `SLTX_ENC_NP};            // [RULE7]
    assign cfg_oct[9]  = {`SLTX_JESDV, `SLTX_ENC_S};                // [RULE8]
    assign cfg_oct[10] = 8'h00;                                     // hd, cf zero [RULE10]
    assign cfg_oct[11] = 8'h00;                                     // reserved 1 [RULE10]
    assign cfg_oct[12] = 8'h00;                                     // reserved 2 [RULE10]
    assign cfg_oct[13] = fchk;                                      // [RULE20]

    // frame and multiframe boundaries; two octets per frame [RULE2] [RULE1]
    wire         frame_end = octet_sel;
    wire         mf_end    = frame_end && (frame_cnt == 6'(k_frames - 6'h01));
    wire         ila_done  = mf_end && (mf_cnt == `SLTX_ILA_MF);    // [RULE21]

    // alignment octet at current position
    wire  [6:0]  oct_idx   = {frame_cnt, octet_sel};
    wire         ila_last  = (oct_idx == 7'({k_frames, 1'b0} - 7'h01));
    wire         ila_cfg   = (mf_cnt == 2'h1) && (oct_idx >= 7'h02) && (oct_idx < 7'h10);
    wire  [3:0]  cfg_sel   = 4'(oct_idx - 7'h02);
    logic [7:0]  ila_oct;
    logic        ila_k;
    always_comb begin
        ila_oct = 8'(oct_idx);
        ila_k   = 1'b0;
        if (oct_idx == 7'h00) begin
            ila_oct = `SLTX_K28_0;
            ila_k   = 1'b1;
        end else if ((mf_cnt == 2'h1) && (oct_idx == 7'h01)) begin
            ila_oct = `SLTX_K28_4;
            ila_k   = 1'b1;
        end else if (ila_last) begin
            ila_oct = `SLTX_K28_3;
            ila_k   = 1'b1;
        end else if (ila_cfg) begin
            ila_oct = cfg_oct[cfg_sel];
        end
    end

    // payload select and scrambler [RULE13]
    wire  [15:0] src_word  = (tpat == sltx_pkg::SLTX_PAT_RAMP) ? ramp_val : held_sample; // [RULE19]
    wire  [7:0]  raw_oct   = octet_sel ? src_word[7:0] : src_word[15:8];
    logic [14:0] next_lfsr;
    logic [7:0]  scr_oct;
    always_comb begin
        next_lfsr = lfsr;
        scr_oct   = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            scr_oct[i] = raw_oct[i] ^ next_lfsr[13] ^ next_lfsr[14];
            next_lfsr  = {next_lfsr[13:0], scr_oct[i]};
        end
    end

    // register bus decode
    wire         wr_go   = aw_held && w_held && !s_axi_bvalid;
    wire         wr_ctrl = wr_go && (aw_addr == `SLTX_CTRL_ADDR);
    wire         wr_k    = wr_go && (aw_addr == `SLTX_KCFG_ADDR);
    wire         wr_step = wr_go && (aw_addr == `SLTX_STEP_ADDR);
    wire         wr_ok   = wr_ctrl || wr_k || wr_step || (aw_addr == `SLTX_STAT_ADDR);
    wire  [2:0]  new_pat = w_data[`SLTX_CTRL_TPAT_LSB +: `SLTX_CTRL_TPAT_W];
    wire  [5:0]  new_k   = w_data[5:0];
    wire         k_legal = (new_k >= `SLTX_K_MIN) && (new_k <= `SLTX_K_MAX);
    wire         rd_go   = s_axi_arvalid && !s_axi_rvalid;
    logic [31:0] rd_data;
    logic        rd_ok;
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b1;
        if (s_axi_araddr == `SLTX_CTRL_ADDR) begin
            rd_data = {25'h0, tpat, 3'h0, scr_en};
        end else if (s_axi_araddr == `SLTX_KCFG_ADDR) begin
            rd_data = {26'h0, k_frames};
        end else if (s_axi_araddr == `SLTX_STEP_ADDR) begin
            rd_data = {16'h0, ramp_step};
        end else if (s_axi_araddr == `SLTX_STAT_ADDR) begin
            rd_data = {20'h0, mf_cnt, frame_cnt, 1'b0, sync_req, 2'(state)};
        end else begin
            rd_ok   = 1'b0;
        end
    end

    // AXI write side
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
        end
    end

    // AXI read side
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= rd_go && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // bad pattern codes and K dropped [RULE18]
    wire  [31:0] ctrl_rst = `SLTX_CTRL_RST;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            scr_en    <= ctrl_rst[`SLTX_CTRL_SCR_BIT];                    // [RULE13]
            tpat      <= sltx_pkg::SLTX_PAT_DATA;
            k_frames  <= `SLTX_K_RST;
            ramp_step <= `SLTX_STEP_RST;
        end else begin
            if (wr_ctrl && w_strb[0]) begin
                scr_en <= w_data[`SLTX_CTRL_SCR_BIT];                     // [RULE13]
                if (new_pat <= 3'(sltx_pkg::SLTX_PAT_RAMP)) begin
                    tpat <= sltx_pkg::sltx_pat_t'(new_pat);               // [RULE16]
                end
            end
            if (wr_k && w_strb[0] && k_legal) begin
                k_frames <= new_k;                                        // [RULE5]
            end
            if (wr_step) begin
                if (w_strb[0]) ramp_step[7:0]  <= w_data[7:0];
                if (w_strb[1]) ramp_step[15:8] <= w_data[15:8];
            end
        end
    end

    // sync request: two flops, then a low must last four frames [RULE22]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sync_meta    <= 1'b1;
            sync_s       <= 1'b1;
            sync_low_cnt <= 3'h0;
            sync_req     <= 1'b0;
        end else begin
            sync_meta <= link_sync_request_n;
            sync_s    <= sync_meta;
            if (sync_s) begin
                sync_low_cnt <= 3'h0;
                sync_req     <= 1'b0;
            end else if (frame_end && (sync_low_cnt != `SLTX_SYNC_MIN)) begin
                sync_low_cnt <= 3'(sync_low_cnt + 3'h1);
            end else if (sync_low_cnt == `SLTX_SYNC_MIN) begin
                sync_req     <= 1'b1;                                     // [RULE22]
            end
        end
    end

    // frame counters and link state
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            octet_sel   <= 1'b0;
            frame_cnt   <= 6'h00;
            mf_cnt      <= 2'h0;
            state       <= sltx_pkg::SLTX_ST_CGS;
            held_sample <= 16'h0000;
        end else begin
            octet_sel <= !octet_sel;
            if (frame_end) begin
                held_sample <= sample_data;
                frame_cnt   <= mf_end ? 6'h00 : 6'(frame_cnt + 6'h01);
            end
            case (state)
                sltx_pkg::SLTX_ST_CGS: begin
                    mf_cnt <= 2'h0;
                    if (mf_end && !sync_req && (tpat != sltx_pkg::SLTX_PAT_K285)
                        && (tpat != sltx_pkg::SLTX_PAT_D215)) begin
                        state <= sltx_pkg::SLTX_ST_ILA;                    // [RULE21]
                    end
                end
                sltx_pkg::SLTX_ST_ILA: begin
                    if (sync_req) begin
                        state <= sltx_pkg::SLTX_ST_CGS;
                    end else if (mf_end) begin
                        mf_cnt <= 2'(mf_cnt + 2'h1);
                        if (ila_done && (tpat != sltx_pkg::SLTX_PAT_ILA)) begin
                            state <= sltx_pkg::SLTX_ST_DATA;              // [RULE21] [RULE16]
                        end
                    end
                end
                sltx_pkg::SLTX_ST_DATA: begin
                    if (sync_req || (tpat == sltx_pkg::SLTX_PAT_K285)
                        || (tpat == sltx_pkg::SLTX_PAT_D215)
                        || (tpat == sltx_pkg::SLTX_PAT_ILA)) begin
                        state <= sltx_pkg::SLTX_ST_CGS;                   // [RULE16]
                    end
                end
                default: state <= sltx_pkg::SLTX_ST_CGS;
            endcase
        end
    end

    // scrambler runs through alignment for early lock; octets stay plain
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            lfsr             <= 15'h7FFF;
            ramp_val         <= 16'h0000;
            lane_octet       <= `SLTX_K28_5;
            lane_is_ctrl     <= 1'b1;
            lane_frame_start <= 1'b0;
        end else begin
            lane_frame_start <= !octet_sel;
            if (state == sltx_pkg::SLTX_ST_DATA) begin
                lane_octet   <= scr_en ? scr_oct : raw_oct;               // [RULE13]
                lane_is_ctrl <= 1'b0;
                lfsr         <= next_lfsr;
                if (frame_end) begin
                    ramp_val <= 16'(ramp_val + ramp_step);                 // [RULE19]
                end
            end else if (state == sltx_pkg::SLTX_ST_ILA) begin
                lane_octet   <= ila_oct;                                  // [RULE15]
                lane_is_ctrl <= ila_k;
                lfsr         <= scr_en ? next_lfsr : lfsr;                // [RULE14]
                ramp_val     <= 16'h0000;
            end else if (tpat == sltx_pkg::SLTX_PAT_D215) begin
                lane_octet   <= `SLTX_D21_5;                              // [RULE17]
                lane_is_ctrl <= 1'b0;
            end else begin
                lane_octet   <= `SLTX_K28_5;                              // [RULE16]
                lane_is_ctrl <= 1'b1;
            end
        end
    end

endmodule : sltx_top

// >>> sltx_map.svh
/*
 * offsets, fields, reset values and link constants of the transmitter.
 * assumes inclusion by bare name.
 */
`ifndef SLTX_MAP_SVH
`define SLTX_MAP_SVH

// register byte offsets
`define SLTX_CTRL_ADDR      8'h00
`define SLTX_KCFG_ADDR      8'h04
`define SLTX_STEP_ADDR      8'h08
`define SLTX_STAT_ADDR      8'h0C

// control register fields
`define SLTX_CTRL_SCR_BIT   0
`define SLTX_CTRL_TPAT_LSB  4
`define SLTX_CTRL_TPAT_W    3

// reset values
`define SLTX_CTRL_RST       32'h0000_0000
`define SLTX_K_RST          6'h20
`define SLTX_STEP_RST       16'h0001

// frame limits
`define SLTX_K_MIN          6'h09
`define SLTX_K_MAX          6'h20
`define SLTX_ILA_MF         2'h3
`define SLTX_SYNC_MIN       3'h4

// fixed link parameters, encoded
`define SLTX_LINE_RATIO     20
`define SLTX_ENC_F          8'h01
`define SLTX_ENC_L          5'h00
`define SLTX_ENC_M          8'h01
`define SLTX_ENC_N          5'h0F
`define SLTX_ENC_NP         5'h0F
`define SLTX_ENC_S          5'h00
`define SLTX_JESDV          3'h1
`define SLTX_SUBCLASS       3'h1
`define SLTX_FCHK_BASE      8'h22

// control characters and the D21.5 data character
`define SLTX_K28_5          8'hBC
`define SLTX_K28_0          8'h1C
`define SLTX_K28_3          8'h7C
`define SLTX_K28_4          8'h9C
`define SLTX_D21_5          8'hB5

`endif

// >>> sltx_pkg.sv
/*
 * types for the single-lane transport and alignment transmitter.
 * assumes sltx_map.svh is on the include path.
 */
package sltx_pkg;
    typedef enum logic [2:0] {
        SLTX_PAT_DATA,
        SLTX_PAT_D215,
        SLTX_PAT_K285,
        SLTX_PAT_ILA,
        SLTX_PAT_RAMP
    } sltx_pat_t;

    typedef enum {
        SLTX_ST_CGS,
        SLTX_ST_ILA,
        SLTX_ST_DATA
    } sltx_state_t;
endpackage : sltx_pkg

// >>> sltx_top_props.sv
/*
 * checker for the lane side of sltx_top.
 * assumes one clock core_clk; bound to sltx_top below.
 */
module sltx_top_chk (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rstn,
    // sync request and lane
    input wire logic       link_sync_request_n,
    input wire logic [7:0] lane_octet,
    input wire logic       lane_is_ctrl,
    input wire logic       lane_frame_start
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    logic       q_seen;
    logic [4:0] low_cnt;

    assign q_seen = lane_is_ctrl && (lane_octet == 8'h9C);

    // saturates; only the current low run matters
    always_ff @(posedge core_clk) begin
        if (!rstn || link_sync_request_n) begin
            low_cnt <= 5'h00;
        end else if (low_cnt != 5'h1F) begin
            low_cnt <= low_cnt + 5'h01;
        end
    end

    property p_fs_alt;
        $past(rstn, 2) |-> lane_frame_start != $past(lane_frame_start);
    endproperty
    a_fs_alt: assert property (p_fs_alt) else $error("frame phase");
    property p_ila_head;
        (lane_is_ctrl && lane_octet == 8'h1C) |-> lane_frame_start;
    endproperty
    a_ila_head: assert property (p_ila_head) else $error("ila head");
    property p_cfg_zero;
        q_seen |-> ##1 lane_octet == 8'h00 ##1 lane_octet == 8'h00 ##1 lane_octet == 8'h00;
    endproperty
    a_cfg_zero: assert property (p_cfg_zero) else $error("cfg id");
    property p_cfg_l;
        q_seen |-> ##4 lane_octet[6:0] == 7'h00;
    endproperty
    a_cfg_l: assert property (p_cfg_l) else $error("cfg lanes");
    property p_cfg_f;
        q_seen |-> ##5 lane_octet == 8'h01;
    endproperty
    a_cfg_f: assert property (p_cfg_f) else $error("cfg octets");
    property p_cfg_k;
        q_seen |-> ##6 lane_octet inside {[8'h08:8'h1F]};
    endproperty
    a_cfg_k: assert property (p_cfg_k) else $error("cfg k");
    property p_cfg_m;
        q_seen |-> ##7 lane_octet == 8'h01;
    endproperty
    a_cfg_m: assert property (p_cfg_m) else $error("cfg m");
    property p_cfg_n;
        q_seen |-> ##8 lane_octet == 8'h0F ##1 lane_octet == 8'h2F;
    endproperty
    a_cfg_n: assert property (p_cfg_n) else $error("cfg n");
    property p_cfg_s;
        q_seen |-> ##10 lane_octet == 8'h20;
    endproperty
    a_cfg_s: assert property (p_cfg_s) else $error("cfg s");
    property p_cfg_tail;
        q_seen |-> ##11 lane_octet == 8'h00 ##1 lane_octet == 8'h00 ##1 lane_octet == 8'h00;
    endproperty
    a_cfg_tail: assert property (p_cfg_tail) else $error("cfg tail");
    property p_fchk;
        q_seen |-> ##14 lane_octet ==
            8'h22 + $past(lane_octet, 8) + {7'h00, $past(lane_octet[7], 10)};
    endproperty
    a_fchk: assert property (p_fchk) else $error("cfg fchk");
    // margin covers the two-flop synchroniser, the four-frame filter and the state and output flops
    property p_sync_k;
        low_cnt == 5'd14 |-> lane_is_ctrl && lane_octet == 8'hBC;
    endproperty
    a_sync_k: assert property (p_sync_k) else $error("sync comma");

    c_q: cover property (q_seen);
    c_sync: cover property (low_cnt == 5'd14);
    c_data: cover property (!lane_is_ctrl && lane_frame_start);
endmodule : sltx_top_chk

bind sltx_top sltx_top_chk u_chk (
    .core_clk            (core_clk),
    .rstn                (rstn),
    .link_sync_request_n (link_sync_request_n),
    .lane_octet          (lane_octet),
    .lane_is_ctrl        (lane_is_ctrl),
    .lane_frame_start    (lane_frame_start)
);

// >>> sltx_rx_model.sv
/*
 * receiver model: drives the sync request, captures the lane from the
 * alignment start character on.
 * assumes the bench calls arm and request_sync by hierarchy.
 */
module sltx_rx_model (
    // clock
    input  wire logic       core_clk,
    // lane from the transmitter
    input  wire logic [7:0] lane_octet,
    input  wire logic       lane_is_ctrl,
    input  wire logic       lane_frame_start,
    // sync request back
    output logic            link_sync_request_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] cap_q [0:143];
    int         cap_n;
    logic       armed;

    initial begin
        link_sync_request_n = 1'b1;
        armed = 1'b0;
        cap_n = 0;
    end

    // shorter than four frames is a glitch the sender drops
    task automatic request_sync(input int cycles);
        @(posedge core_clk);
        link_sync_request_n <= 1'b0;
        repeat (cycles) @(posedge core_clk);
        link_sync_request_n <= 1'b1;
    endtask : request_sync

    task automatic arm();
        cap_n = 0;
        armed = 1'b1;
    endtask : arm

    always @(posedge core_clk) begin
        if (armed && (cap_n > 0 || (lane_is_ctrl && lane_octet == 8'h1C))) begin
            cap_q[cap_n] = {lane_is_ctrl, lane_octet};
            cap_n++;
            armed = (cap_n < 144);
        end
    end
endmodule : sltx_rx_model

// >>> test_serial_link_transport_ila_tx.sv
/*
 * self-checking bench for sltx_top: registers over AXI4-Lite, alignment
 * sequence, data, ramp and test patterns.
 * assumes sltx_map.svh on the include path and the receiver model.
 */
`include "sltx_map.svh"
module test_serial_link_transport_ila_tx;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rstn, link_sync_request_n, lane_is_ctrl, lane_frame_start;
    logic [15:0] sample_data;
    logic [7:0]  lane_octet, s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int errors = 0;
    int check_count = 0;

    sltx_top dut (.*);
    sltx_rx_model rx (.*);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic summarize();
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        while (!s_axi_bvalid) @(posedge core_clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
    endtask : wr

    task automatic rd_expect(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check($sformatf("reg %h", a), d & m, e);
    endtask : rd_expect

    // releases sync and waits for alignment plus one alignment length of data
    task automatic run_ila();
        rx.arm();
        rx.request_sync(20);
        while (rx.cap_n < 144) @(posedge core_clk);
    endtask : run_ila

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        rd_expect(`SLTX_CTRL_ADDR, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_expect(`SLTX_KCFG_ADDR, 32'h0000_003F, 32'h0000_0020);
        rd_expect(`SLTX_STEP_ADDR, 32'h0000_FFFF, 32'h0000_0001);
        axi_rd(8'h10, d, r);
        check("unmapped rresp", r, 2'h2);
        axi_wr(8'h10, 32'h0000_0001, r);
        check("unmapped bresp", r, 2'h2);
        wr(`SLTX_KCFG_ADDR, 32'h0000_0008);
        wr(`SLTX_KCFG_ADDR, 32'h0000_0021);
        rd_expect(`SLTX_KCFG_ADDR, 32'h0000_003F, 32'h0000_0020);
        wr(`SLTX_KCFG_ADDR, 32'h0000_0009);
        rd_expect(`SLTX_KCFG_ADDR, 32'h0000_003F, 32'h0000_0009);
    endtask : t_regs

    // K of nine, scrambling on: 72 alignment octets
    task automatic t_ila();
        logic [7:0] cfg [0:13] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h01, 8'h08, 8'h01,
                                   8'h0F, 8'h2F, 8'h20, 8'h00, 8'h00, 8'h00, 8'h2B};
        int same = 0;
        wr(`SLTX_CTRL_ADDR, 32'h0000_0001);
        run_ila();
        check("ila start", rx.cap_q[0], 9'h11C);
        check("ila filler", rx.cap_q[2], 9'h002);
        check("mf0 end", rx.cap_q[17], 9'h17C);
        check("cfg start", rx.cap_q[19], 9'h19C);
        for (int i = 0; i < 14; i++) check($sformatf("cfg %0d", i), rx.cap_q[20 + i], cfg[i]);
        check("mf3 end", rx.cap_q[71], 9'h17C);
        for (int i = 72; i < 144; i += 2) same += (rx.cap_q[i] == 9'h0A5);
        check("scrambled", same == 36, 1'b0);
        rd_expect(`SLTX_STAT_ADDR, 32'h0000_0003, 32'h0000_0002);
    endtask : t_ila

    task automatic t_data();
        wr(`SLTX_CTRL_ADDR, 32'h0000_0000);
        run_ila();
        check("data msb", rx.cap_q[72], 9'h0A5);
        check("data lsb", rx.cap_q[73], 9'h0C3);
    endtask : t_data

    task automatic t_ramp();
        logic [15:0] v0, v1;
        wr(`SLTX_STEP_ADDR, 32'h0000_0003);
        wr(`SLTX_CTRL_ADDR, 32'h0000_0040);
        run_ila();
        v0 = {rx.cap_q[72][7:0], rx.cap_q[73][7:0]};
        v1 = {rx.cap_q[74][7:0], rx.cap_q[75][7:0]};
        check("ramp start", v0, 16'h0000);
        check("ramp step", v1 - v0, 16'h0003);
    endtask : t_ramp

    task automatic t_short();
        rx.request_sync(3);
        repeat (20) @(posedge core_clk);
        rd_expect(`SLTX_STAT_ADDR, 32'h0000_0003, 32'h0000_0002);
    endtask : t_short

    task automatic t_pats();
        wr(`SLTX_CTRL_ADDR, 32'h0000_0030);
        rx.arm();
        while (rx.cap_n < 144) @(posedge core_clk);
        check("ila repeat", rx.cap_q[72], 9'h11C);
        wr(`SLTX_CTRL_ADDR, 32'h0000_0010);
        repeat (100) @(posedge core_clk);
        check("d21.5", {lane_is_ctrl, lane_octet}, 9'h0B5);
        wr(`SLTX_CTRL_ADDR, 32'h0000_0020);
        repeat (4) @(posedge core_clk);
        check("k28.5", {lane_is_ctrl, lane_octet}, 9'h1BC);
        wr(`SLTX_CTRL_ADDR, 32'h0000_0050);
        rd_expect(`SLTX_CTRL_ADDR, 32'h0000_0071, 32'h0000_0020);
    endtask : t_pats

    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        summarize();
    end

    initial begin
        rstn <= 1'b0;
        sample_data <= 16'hA5C3;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= 52'h0;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        t_regs();
        t_ila();
        t_data();
        t_ramp();
        t_short();
        t_pats();
        summarize();
    end
endmodule : test_serial_link_transport_ila_tx
